/* File: rtl/lpc_pkg.sv */
package lpc_pkg;

	localparam int unsigned MCLK_HZ = 100_000_000;
	localparam int unsigned OSC_HZ = 16_000_000;
	// 16 MHz made from mclk by a fractional accumulator (+16 mod 100)
	localparam logic [8:0] OSC_STEP = 9'(OSC_HZ / 1_000_000);
	localparam logic [8:0] OSC_MOD = 9'(MCLK_HZ / 1_000_000);

	localparam int NUM_OUT = 18;
	localparam int GRP_SIZE = 3;
	localparam int NUM_GRP = 6;
	localparam int DC_BANK = 6;
	localparam int DUTY_BYTES = 2 * NUM_OUT;
	localparam int STAT_PER_REG = 4;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DUTY_FIRST = 8'h01;
	localparam logic [7:0] ADDR_DUTY_LAST = 8'h24;
	localparam logic [7:0] ADDR_PHASE = 8'h70;
	localparam logic [7:0] ADDR_DETECT = 8'h71;
	localparam logic [7:0] ADDR_STAT_FIRST = 8'h72;
	localparam logic [7:0] ADDR_STAT_LAST = 8'h76;
	localparam logic [7:0] ADDR_SPREAD = 8'h78;

	localparam logic [1:0] RES_8 = 2'h0;
	localparam logic [1:0] RES_10 = 2'h1;
	localparam logic [1:0] RES_12 = 2'h2;
	localparam logic [1:0] RES_16 = 2'h3;
	localparam logic [15:0] MASK_8 = 16'h00FF;
	localparam logic [15:0] MASK_10 = 16'h03FF;
	localparam logic [15:0] MASK_12 = 16'h0FFF;
	localparam logic [15:0] MASK_16 = 16'hFFFF;
	localparam logic [15:0] SIXTH_8 = 16'(256 / NUM_GRP);
	localparam logic [15:0] SIXTH_10 = 16'(1024 / NUM_GRP);
	localparam logic [15:0] SIXTH_12 = 16'(4096 / NUM_GRP);
	localparam logic [15:0] SIXTH_16 = 16'(65536 / NUM_GRP);

	localparam logic [1:0] DET_OFF = 2'h0;
	localparam logic [1:0] DET_SHORT = 2'h2;
	localparam logic [1:0] DET_OPEN = 2'h3;

	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] PRE_ONE = 8'h01;

	typedef struct packed {
		logic spare7;
		logic [2:0] oscillatorSelect;
		logic spare3;
		logic [1:0] pwmResolutionSelect;
		logic softShutdown_n;
	} lpc_ctrl_s;

	typedef struct packed {
		logic spare7;
		logic groupDelayEnable;
		logic [NUM_GRP-1:0] groupClockPhaseSelect;
	} lpc_phase_s;

	typedef struct packed {
		logic [2:0] dcMode;
		logic spreadEnable;
		logic [1:0] spreadRange;
		logic [1:0] spreadCycle;
	} lpc_spread_s;

endpackage

/* File: rtl/lpc_led_pwm.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1 - reset gives 8-bit resolution, about 62 kHz, from a 16 MHz oscillator
// RULE2 - control register 00h picks frequency 122 Hz to 62 kHz via two fields; code goes down to about 1.9 Hz (oscillator select 7, 16-bit)
// RULE3 - with delay and clock phase off, all outputs turn on at cycle start
// RULE4 - delay enable bit in 70h staggers output turn-on
// RULE5 - eighteen outputs form six groups of three, outputs one to three first
// RULE6 - each group starts one sixth period after the group before it
// RULE7 - clock phase bit 0: all halves of the group turn on at cycle start
// RULE8 - clock phase bit 1: first current half still turns on at cycle start
// RULE9 - clock phase bit 1: second current half turns off at cycle end
// RULE10 - group delay and clock phase split apply together
// RULE11 - detect field 00 to 10 captures shorts, 00 to 11 captures opens
// RULE12 - host reads captured results at 72h to 76h
// RULE13 - range field of 78h picks spreading of 5, 15, 24 or 34 percent
// RULE14 - duty has 256, 1024, 4096 or 65536 steps per resolution
// RULE15 - no shutdown mode alters any register
// RULE16 - soft shutdown bit of 00h at 0 enters software shutdown
// RULE17 - software shutdown darkens all outputs, registers stay accessible
// RULE18 - shutdown pin low enters hardware shutdown, analog disabled
// RULE19 - shutdown pin high leaves hardware shutdown
// RULE20 - shutdown pin rising edge resets host interface logic only
// RULE21 - registers stay accessible during hardware shutdown
// RULE22 - group offset is whole oscillator ticks, one sixth of the period
module lpc_led_pwm
	import lpc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata_r,
	input wire logic hard_shutdown_n_pin,
	input wire logic [NUM_OUT-1:0] shortSense,
	input wire logic [NUM_OUT-1:0] openSense,
	output logic [NUM_OUT-1:0] ledOutA_r,
	output logic [NUM_OUT-1:0] ledOutB_r,
	output logic analogEnable_r,
	output logic hostIfReset_r,
	output logic spreadEnable_r,
	output logic [1:0] spreadRange_r,
	output logic [1:0] spreadCycle_r
);

	lpc_ctrl_s ctrl_r;
	lpc_phase_s phase_r;
	lpc_spread_s spread_r;
	logic [1:0] detect_r;
	logic [NUM_OUT-1:0] faultStat_r;
	logic [7:0] dutyMem [DUTY_BYTES];

	logic [8:0] oscAcc_r;
	logic [8:0] oscSum;
	logic oscTick;
	logic [7:0] preCnt_r;
	logic [7:0] preLimit;
	logic pwmTick;
	logic [15:0] cnt_r;
	logic [15:0] periodMask;
	logic [15:0] sixth;
	logic pinPrev_r;
	logic outputsActive;
	logic [NUM_OUT-1:0] ledNxtA;
	logic [NUM_OUT-1:0] ledNxtB;
	logic [15:0] grpOff [NUM_GRP];
	logic [7:0] readMux;

	logic wrCtrl;
	logic wrPhase;
	logic wrDetect;
	logic wrSpread;
	logic wrDuty;
	logic [7:0] dutyIdx;
	logic inDuty;
	logic inStat;
	logic detFromOff;
	logic detToShort;
	logic detToOpen;

	assign wrCtrl = regWr && (regAddr == ADDR_CTRL);
	assign wrPhase = regWr && (regAddr == ADDR_PHASE);
	assign wrDetect = regWr && (regAddr == ADDR_DETECT);
	assign wrSpread = regWr && (regAddr == ADDR_SPREAD);
	assign inDuty = (regAddr >= ADDR_DUTY_FIRST) &&
		(regAddr <= ADDR_DUTY_LAST);
	assign inStat = (regAddr >= ADDR_STAT_FIRST) &&
		(regAddr <= ADDR_STAT_LAST);
	assign wrDuty = regWr && inDuty;
	assign dutyIdx = regAddr - ADDR_DUTY_FIRST;

	// a capture needs the field to leave 00 in this very write
	assign detFromOff = wrDetect && (detect_r == DET_OFF);
	assign detToShort = detFromOff && (regWdata[1:0] == DET_SHORT);
	assign detToOpen = detFromOff && (regWdata[1:0] == DET_OPEN);

	// register writes take effect regardless of either shutdown
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= lpc_ctrl_s'(REG_RST); // [RULE1]
		end else if (ce && wrCtrl) begin
			ctrl_r <= lpc_ctrl_s'(regWdata); // [RULE2] [RULE16] [RULE21]
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			phase_r <= lpc_phase_s'(REG_RST); // [RULE3]
		end else if (ce && wrPhase) begin
			phase_r <= lpc_phase_s'(regWdata);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			spread_r <= lpc_spread_s'(REG_RST);
		end else if (ce && wrSpread) begin
			spread_r <= lpc_spread_s'(regWdata);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (int k = 0; k < DUTY_BYTES; k++) begin
				dutyMem[k] <= REG_RST;
			end
		end else if (ce && wrDuty) begin
			dutyMem[dutyIdx[5:0]] <= regWdata;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			detect_r <= DET_OFF;
		end else if (ce && wrDetect) begin
			detect_r <= regWdata[1:0];
		end
	end

	// capture only on the transition out of 00; rewriting 10 keeps old result
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			faultStat_r <= '0;
		end else if (ce && detToShort) begin
			faultStat_r <= shortSense; // [RULE11]
		end else if (ce && detToOpen) begin
			faultStat_r <= openSense; // [RULE11]
		end
	end

	// status packs four outputs per byte on the odd bit positions
	function automatic logic [7:0] statByte(input logic [2:0] idx,
		input logic [NUM_OUT-1:0] stat);
		logic [7:0] b;
		int n;
		b = '0;
		for (int j = 0; j < STAT_PER_REG; j++) begin
			n = int'(idx) * STAT_PER_REG + j;
			if (n < NUM_OUT) begin
				b[2 * j + 1] = stat[n];
			end
		end
		return b;
	endfunction

	always_comb begin
		readMux = '0;
		if (regAddr == ADDR_CTRL) begin
			readMux = ctrl_r;
		end else if (inDuty) begin
			readMux = dutyMem[dutyIdx[5:0]];
		end else if (regAddr == ADDR_PHASE) begin
			readMux = phase_r;
		end else if (regAddr == ADDR_DETECT) begin
			readMux = {6'h00, detect_r};
		end else if (inStat) begin
			readMux = statByte(3'(regAddr - ADDR_STAT_FIRST),
				faultStat_r); // [RULE12]
		end else if (regAddr == ADDR_SPREAD) begin
			readMux = spread_r;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			regRdata_r <= '0;
		end else if (ce) begin
			if (regRd) begin
				regRdata_r <= readMux; // [RULE17] [RULE21]
			end else begin
				regRdata_r <= '0;
			end
		end
	end

	// oscillator tick: mean 16 MHz, jitter of one mclk period per tick
	assign oscSum = oscAcc_r + OSC_STEP;
	assign oscTick = oscSum >= OSC_MOD;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			oscAcc_r <= '0;
		end else if (ce) begin
			if (oscTick) begin
				oscAcc_r <= oscSum - OSC_MOD; // [RULE1]
			end else begin
				oscAcc_r <= oscSum;
			end
		end
	end

	// oscillator select divides the tick by a power of two
	assign preLimit = (PRE_ONE << ctrl_r.oscillatorSelect) - PRE_ONE;
	assign pwmTick = oscTick && (preCnt_r >= preLimit);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			preCnt_r <= '0;
		end else if (ce && oscTick) begin
			if (preCnt_r >= preLimit) begin
				preCnt_r <= '0; // [RULE2]
			end else begin
				preCnt_r <= preCnt_r + PRE_ONE;
			end
		end
	end

	always_comb begin
		case (ctrl_r.pwmResolutionSelect)
			RES_8: begin
				periodMask = MASK_8;
				sixth = SIXTH_8;
			end
			RES_10: begin
				periodMask = MASK_10;
				sixth = SIXTH_10;
			end
			RES_12: begin
				periodMask = MASK_12;
				sixth = SIXTH_12;
			end
			RES_16: begin
				periodMask = MASK_16;
				sixth = SIXTH_16;
			end
			default: begin
				periodMask = MASK_8;
				sixth = SIXTH_8;
			end
		endcase
	end

	// masking keeps the count legal after a resolution change mid-cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= '0;
		end else if (ce && pwmTick) begin
			cnt_r <= (cnt_r + 16'h0001) & periodMask; // [RULE14] [RULE2]
		end
	end

	generate
		for (genvar g = 0; g < NUM_GRP; g++) begin : grp
			logic [31:0] offWide;
			assign offWide = g * sixth;
			// offset counted in pwm ticks, floor of a sixth of the period
			assign grpOff[g] = phase_r.groupDelayEnable ?
				offWide[15:0] : '0; // [RULE6] [RULE22] [RULE4] [RULE3]
		end
	endgenerate

	generate
		for (genvar i = 0; i < NUM_OUT; i++) begin : chan
			logic [15:0] localCnt;
			logic [15:0] duty;
			logic [16:0] tailSum;
			logic dcOn;
			logic clkPhase;
			logic onFront;
			logic onTail;
			// group of output i is i / 3
			assign localCnt = (cnt_r - grpOff[i / GRP_SIZE]) &
				periodMask; // [RULE5] [RULE10]
			assign duty = {dutyMem[2 * i + 1], dutyMem[2 * i]} &
				periodMask; // [RULE14]
			assign tailSum = {1'b0, localCnt} + {1'b0, duty};
			assign dcOn = spread_r.dcMode[i / DC_BANK];
			assign clkPhase =
				phase_r.groupClockPhaseSelect[i / GRP_SIZE];
			// front-aligned pulse: on from cycle start for duty counts
			assign onFront = localCnt < duty; // [RULE7] [RULE8]
			// tail-aligned pulse: off exactly at cycle end
			assign onTail = tailSum > {1'b0, periodMask}; // [RULE9]
			assign ledNxtA[i] = outputsActive && (dcOn || onFront);
			assign ledNxtB[i] = outputsActive &&
				(dcOn || (clkPhase ? onTail : onFront)); // [RULE7]
		end
	endgenerate

	// shutdown gates the outputs only, never a register
	assign outputsActive = ctrl_r.softShutdown_n &&
		hard_shutdown_n_pin; // [RULE15] [RULE16] [RULE17] [RULE18]

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ledOutA_r <= '0;
		end else if (ce) begin
			ledOutA_r <= ledNxtA; // [RULE17]
		end
	end

	// second half kept apart: its phase may differ from the first
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ledOutB_r <= '0;
		end else if (ce) begin
			ledOutB_r <= ledNxtB; // [RULE17]
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			analogEnable_r <= 1'b0;
		end else if (ce) begin
			analogEnable_r <= hard_shutdown_n_pin; // [RULE18] [RULE19]
		end
	end

	// reset value high so a pin already high at release gives no pulse
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pinPrev_r <= 1'b1;
		end else if (ce) begin
			pinPrev_r <= hard_shutdown_n_pin;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hostIfReset_r <= 1'b0;
		end else if (ce) begin
			hostIfReset_r <= hard_shutdown_n_pin && !pinPrev_r; // [RULE20]
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			spreadEnable_r <= 1'b0;
		end else if (ce) begin
			spreadEnable_r <= spread_r.spreadEnable;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			spreadRange_r <= '0;
		end else if (ce) begin
			spreadRange_r <= spread_r.spreadRange; // [RULE13]
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			spreadCycle_r <= '0;
		end else if (ce) begin
			spreadCycle_r <= spread_r.spreadCycle;
		end
	end

endmodule

`default_nettype wire

/* File: tb/lpc_led_string.sv */
`timescale 1ns/1ps
`default_nettype none
module lpc_led_string
	import lpc_pkg::*;
(
	input wire logic [NUM_OUT-1:0] shortMask,
	input wire logic [NUM_OUT-1:0] openMask,
	output logic [NUM_OUT-1:0] shortSense,
	output logic [NUM_OUT-1:0] openSense
);
	// wiring faults show as steady comparator levels, lit or dark
	assign shortSense = shortMask;
	assign openSense = openMask;
endmodule
`default_nettype wire

/* File: tb/lpc_led_pwm_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module lpc_led_pwm_properties
	import lpc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdata_r,
	input wire logic hard_shutdown_n_pin,
	input wire logic [NUM_OUT-1:0] ledOutA_r,
	input wire logic [NUM_OUT-1:0] ledOutB_r,
	input wire logic analogEnable_r,
	input wire logic hostIfReset_r,
	input wire logic [1:0] spreadRange_r
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic dark;
	logic pin;
	assign dark = ledOutA_r == '0 && ledOutB_r == '0;
	assign pin = hard_shutdown_n_pin;
	chk_read_idle: assert property (
		ce && !regRd |=> regRdata_r == 8'h00)
		else $error("read data outside read slot");
	chk_soft_dark: assert property (
		regWr && regAddr == ADDR_CTRL && !regWdata[0] |-> ##2 dark)
		else $error("lit in soft shutdown");
	chk_hard_dark: assert property (
		(!pin) [*2] |=> dark)
		else $error("lit in hard shutdown");
	chk_analog_follow: assert property (
		$past(reset_n) && $past(ce) |-> analogEnable_r == $past(pin))
		else $error("analog enable not following pin");
	chk_pin_pulse: assert property (
		$rose(pin) |-> ##[1:2] hostIfReset_r)
		else $error("no host reset pulse");
	chk_pulse_single: assert property (
		hostIfReset_r |=> !hostIfReset_r)
		else $error("host reset pulse too long");
	chk_pulse_cause: assert property (
		hostIfReset_r |-> analogEnable_r && !($past(pin, 2) && $past(pin, 3)))
		else $error("host reset pulse without pin rise");
	chk_spread_range: assert property (
		regWr && regAddr == ADDR_SPREAD |->
		##2 {4'h0, spreadRange_r, 2'h0} == ($past(regWdata, 2) & 8'h0C))
		else $error("spread range not copied");
	cover property (regWr && regAddr == ADDR_CTRL && !regWdata[0]);
	cover property ($rose(pin));
	cover property (regWr && regAddr == ADDR_SPREAD);
endmodule
bind lpc_led_pwm lpc_led_pwm_properties u_chk (.mclk, .reset_n, .ce, .regAddr,
	.regWdata, .regWr, .regRd, .regRdata_r, .hard_shutdown_n_pin, .ledOutA_r,
	.ledOutB_r, .analogEnable_r, .hostIfReset_r, .spreadRange_r);
`default_nettype wire

/* File: tb/lpc_led_pwm_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lpc_led_pwm_tb_top
	import lpc_pkg::*;
;
	localparam logic [17:0] SHORT_PAT = 18'h2A5C3;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic ce = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic hard_shutdown_n_pin = 1'b1;
	logic [NUM_OUT-1:0] shortMask = SHORT_PAT;
	logic [NUM_OUT-1:0] openMask = 18'h15A3C;
	logic [NUM_OUT-1:0] shortSense, openSense, ledOutA_r, ledOutB_r;
	logic [7:0] regRdata_r;
	logic analogEnable_r, hostIfReset_r, spreadEnable_r;
	logic [1:0] spreadRange_r, spreadCycle_r;
	logic [7:0] ctrlTab [3] = '{8'h01, 8'h03, 8'h11};
	int perTab [3] = '{1600, 6400, 3200};
	int hiTab [3] = '{800, 800, 1600};
	int mismatches = 0;
	int totalChecks = 0;
	int cyc = 0;
	int t0;
	always #5 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;
	lpc_led_pwm dut (.mclk, .reset_n, .ce, .regAddr, .regWdata, .regWr, .regRd,
		.regRdata_r, .hard_shutdown_n_pin, .shortSense, .openSense, .ledOutA_r,
		.ledOutB_r, .analogEnable_r, .hostIfReset_r, .spreadEnable_r,
		.spreadRange_r, .spreadCycle_r);
	lpc_led_string u_str (.shortMask, .openMask, .shortSense, .openSense);
	task automatic endSim();
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	// tick is 16 MHz on average, so edges jitter by an mclk or two
	task automatic near(input int got, input int exp);
		check((got > exp - 8 && got < exp + 8) ? exp : got, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		check(regRdata_r, exp);
	endtask
	task automatic waitEdge(input int i, input bit useB, input logic lvl);
		logic prev, cur;
		prev = lvl;
		for (int n = 0; n < 20000; n++) begin
			@(negedge mclk);
			cur = useB ? ledOutB_r[i] : ledOutA_r[i];
			if (cur === lvl && prev === !lvl)
				return;
			prev = cur;
		end
		mismatches++;
		endSim();
	endtask
	function automatic logic [7:0] stat(input logic [17:0] v, input int k);
		logic [7:0] s;
		s = 8'h00;
		for (int j = 0; j < 4; j++)
			if (4 * k + j < NUM_OUT)
				s[2 * j + 1] = v[4 * k + j];
		return s;
	endfunction
	initial begin
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		rdChk(ADDR_CTRL, 8'h00);
		check(ledOutA_r | ledOutB_r, 18'h0);
		for (int i = 0; i < NUM_OUT; i++)
			wr(8'(ADDR_DUTY_FIRST + 2 * i), 8'h80);
		for (int r = 0; r < 3; r++) begin
			wr(ADDR_CTRL, ctrlTab[r]);
			waitEdge(0, 0, 1);
			waitEdge(0, 0, 1);
			t0 = cyc;
			check(ledOutA_r & ledOutB_r, 18'h3FFFF);
			waitEdge(0, 0, 0);
			near(cyc - t0, hiTab[r]);
			waitEdge(0, 0, 1);
			near(cyc - t0, perTab[r]);
		end
		$display("done pwm");
		wr(ADDR_CTRL, 8'h01);
		wr(ADDR_PHASE, 8'h40);
		waitEdge(0, 0, 1);
		waitEdge(0, 0, 1);
		t0 = cyc;
		check(ledOutA_r, 18'h3F007);
		for (int g = 1; g < NUM_GRP; g++) begin
			waitEdge(3 * g, 0, 1);
			near(cyc - t0, g * 262);
			check((ledOutA_r >> (3 * g)) & 18'h7, 18'h7);
		end
		wr(ADDR_PHASE, 8'h01);
		waitEdge(0, 0, 1);
		waitEdge(0, 0, 1);
		check(ledOutA_r, 18'h3FFFF);
		check(ledOutB_r, 18'h3FFF8);
		waitEdge(0, 1, 0);
		check(ledOutA_r[0], 1'b1);
		wr(ADDR_PHASE, 8'h42);
		waitEdge(3, 0, 1);
		waitEdge(3, 0, 1);
		check((ledOutB_r >> 3) & 18'h7, 18'h0);
		waitEdge(3, 1, 0);
		check(ledOutA_r[5:3], 3'h7);
		$display("done phase");
		wr(ADDR_DETECT, 8'h02);
		shortMask <= 18'h0;
		for (int k = 0; k < 5; k++)
			rdChk(8'(ADDR_STAT_FIRST + k), stat(SHORT_PAT, k));
		wr(ADDR_DETECT, 8'h00);
		wr(ADDR_DETECT, 8'h03);
		for (int k = 0; k < 5; k++)
			rdChk(8'(ADDR_STAT_FIRST + k), stat(openMask, k));
		rdChk(8'h50, 8'h00);
		for (int r = 0; r < 4; r++) begin
			wr(ADDR_SPREAD, {4'h1, 2'(r), 2'h1});
			@(posedge mclk);
			@(negedge mclk);
			check({spreadEnable_r, spreadRange_r, spreadCycle_r},
				{1'b1, 2'(r), 2'h1});
		end
		wr(ADDR_SPREAD, 8'h3D);
		waitEdge(6, 0, 0);
		check(ledOutA_r[5:0] & ledOutB_r[5:0], 6'h3F);
		$display("done detect spread");
		wr(ADDR_CTRL, 8'h00);
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		check(ledOutA_r | ledOutB_r, 18'h0);
		rdChk(ADDR_DUTY_FIRST, 8'h80);
		wr(ADDR_SPREAD, 8'h1D);
		rdChk(ADDR_SPREAD, 8'h1D);
		wr(ADDR_CTRL, 8'h01);
		hard_shutdown_n_pin <= 1'b0;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		check({analogEnable_r, ledOutA_r | ledOutB_r}, 19'h0);
		wr(ADDR_PHASE, 8'h15);
		rdChk(ADDR_PHASE, 8'h15);
		@(posedge mclk);
		hard_shutdown_n_pin <= 1'b1;
		t0 = 0;
		repeat (4) begin
			@(negedge mclk);
			if (hostIfReset_r === 1'b1)
				t0++;
		end
		check(t0, 1);
		check(analogEnable_r, 1'b1);
		rdChk(ADDR_PHASE, 8'h15);
		waitEdge(0, 0, 1);
		@(posedge mclk);
		ce <= 1'b0;
		wr(ADDR_PHASE, 8'h00);
		ce <= 1'b1;
		rdChk(ADDR_PHASE, 8'h15);
		$display("done shutdown");
		endSim();
	end
endmodule
`default_nettype wire
